// [bench/ffr_fan_fail_ramp_assertions.sv]
// port checks of the fan fail block
`timescale 1ns/1ps
`default_nettype none
`include "ffr_defines.svh"
module ffr_fan_fail_ramp_checker #(
    parameter int unsigned TACH_TIMEOUT_CYC = 20
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        speedInputOne,
    input wire logic        speedInputTwo,
    input wire logic        pulseFeatureActive,
    input wire logic        failFlagPinOut,
    input wire logic        failFlagPinOe,
    input wire logic        irq
);
    logic        take;
    logic        wrPend_q;
    logic [7:0]  wrAddr_q;
    logic        pulse_feature_enable_q;
    logic [1:0]  freq_q;
    logic [1:0]  mask_q;
    logic [1:0]  prev_q;
    logic [31:0] idle1_q;
    logic [31:0] idle2_q;
    logic        ctlWr;
    assign take = hsel && hready && htrans[1] && ce;
    assign ctlWr = wrPend_q && wrAddr_q == `FFR_ADDR_CTRL;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= take && hwrite;
            wrAddr_q <= take ? haddr : wrAddr_q;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pulse_feature_enable_q <= 1'b0;
            freq_q <= 2'h0;
            mask_q <= 2'h0;
        end else if (wrPend_q) begin
            pulse_feature_enable_q <= ctlWr ? hwdata[2] : pulse_feature_enable_q;
            freq_q <= wrAddr_q == `FFR_ADDR_CFG ? hwdata[1:0] : freq_q;
            mask_q <= wrAddr_q == `FFR_ADDR_IRQ_MASK ? hwdata[1:0] : mask_q;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_q  <= 2'h0;
            idle1_q <= 32'h0;
            idle2_q <= 32'h0;
        end else begin
            prev_q  <= {speedInputTwo, speedInputOne};
            idle1_q <= (speedInputOne && !prev_q[0]) ? 32'h0 : idle1_q + 32'h1;
            idle2_q <= (speedInputTwo && !prev_q[1]) ? 32'h0 : idle2_q + 32'h1;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("hrdata moved outside read");
    a_pin_low: assert property (failFlagPinOut == 1'b0)
        else $error("fail pin driven high");
    a_fail_cause: assert property ($rose(failFlagPinOe) |->
        idle1_q >= TACH_TIMEOUT_CYC || idle2_q >= TACH_TIMEOUT_CYC)
        else $error("fail pin without stall");
    a_clear_release: assert property (ctlWr && hwdata[7] && idle1_q < 10 && idle2_q < 10
        |-> ##3 !failFlagPinOe)
        else $error("clear kept fail pin");
    a_disable_release: assert property (ctlWr && hwdata[1:0] == 2'b00
        |-> ##3 !failFlagPinOe [*8])
        else $error("disable kept fail pin");
    a_pulse_follow: assert property ($stable({pulse_feature_enable_q, freq_q}) [*4]
        |-> pulseFeatureActive == (pulse_feature_enable_q && freq_q == 2'b00))
        else $error("pulse feature state wrong");
    a_irq_mask: assert property ($rose(irq) |-> mask_q != 2'b00)
        else $error("irq while all masked");
endmodule : ffr_fan_fail_ramp_checker
bind ffr_fan_fail_ramp ffr_fan_fail_ramp_checker #(
    .TACH_TIMEOUT_CYC(TACH_TIMEOUT_CYC)
) ffr_fan_fail_ramp_checker_i (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .speedInputOne(speedInputOne), .speedInputTwo(speedInputTwo),
    .pulseFeatureActive(pulseFeatureActive), .failFlagPinOut(failFlagPinOut),
    .failFlagPinOe(failFlagPinOe), .irq(irq)
);
`default_nettype wire

// [bench/ffr_fan_model.sv]
// cooling fan: tach pulses, held high when stalled
`timescale 1ns/1ps
`default_nettype none
module ffr_fan_model #(
    parameter int unsigned HALF_PERIOD = 4
) (
    input  wire logic sys_clk,
    input  wire logic stall,
    output logic      tach
);
    int unsigned cnt = 0;
    initial tach = 1'b1;
    always @(posedge sys_clk) begin
        if (stall) begin
            tach <= 1'b1;
            cnt  <= 0;
        end else if (cnt == HALF_PERIOD - 1) begin
            tach <= ~tach;
            cnt  <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : ffr_fan_model
`default_nettype wire

// [bench/test_fan_fail_and_ramp_control.sv]
// bench for the fan fail and ramp block
`timescale 1ns/1ps
`default_nettype none
`include "ffr_defines.svh"
module test_fan_fail_and_ramp_control;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic [7:0]  haddr   = 8'h00;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [1:0]  stall   = 2'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        pulseFeatureActive;
    logic        failFlagPinOe;
    logic        irq;
    logic        pwmOut;
    logic        speedOne;
    logic        speedTwo;
    int          n_mismatch = 0;
    int          compares   = 0;
    always #50 sys_clk = ~sys_clk;
    ffr_fan_fail_ramp #(.RAMP_STEP_CYCLES(8), .TACH_TIMEOUT_CYC(20)) ffr_fan_fail_ramp_i (
        .sys_clk(sys_clk), .reset(reset), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .speedInputOne(speedOne), .speedInputTwo(speedTwo), .pwmOut(pwmOut),
        .pulseFeatureActive(pulseFeatureActive), .failFlagPinOut(),
        .failFlagPinOe(failFlagPinOe), .irq(irq));
    ffr_fan_model fan_one_i (.sys_clk(sys_clk), .stall(stall[0]), .tach(speedOne));
    ffr_fan_model fan_two_i (.sys_clk(sys_clk), .stall(stall[1]), .tach(speedTwo));
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_ready(output logic [31:0] q);
        logic rdy;
        do begin
            @(negedge sys_clk);
            rdy = hreadyout;
            q = hrdata;
            @(posedge sys_clk);
        end while (rdy !== 1'b1);
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready(q);
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready(q);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : expect_rd
    task automatic pins(input logic [1:0] exp);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check({30'h0, failFlagPinOe, irq}, {30'h0, exp});
    endtask : pins
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle
    task automatic recover();
        stall <= 2'h0;
        idle(20);
        wr(`FFR_ADDR_CTRL, 32'hB3);
        wr(`FFR_ADDR_IRQ_STAT, 32'h3);
    endtask : recover
    task automatic t_regs();
        expect_rd(`FFR_ADDR_CTRL, 32'h03);
        expect_rd(`FFR_ADDR_IRQ_MASK, 32'h0);
        wr(8'h40, 32'hFF);
        expect_rd(8'h40, 32'h0);
        wr(`FFR_ADDR_CTRL, 32'hBF);
        expect_rd(`FFR_ADDR_CTRL, 32'h3F);
        wr(`FFR_ADDR_CTRL, 32'h33);
        pins(2'b00);
        $display("register test done");
    endtask : t_regs
    task automatic t_fail();
        wr(`FFR_ADDR_CFG, 32'h4);
        wr(`FFR_ADDR_DUTY_TGT, 32'hFF);
        stall <= 2'b01;
        idle(40);
        expect_rd(`FFR_ADDR_FAIL, 32'h1);
        pins(2'b10);
        wr(`FFR_ADDR_IRQ_MASK, 32'h3);
        pins(2'b11);
        stall <= 2'b00;
        idle(40);
        expect_rd(`FFR_ADDR_FAIL, 32'h1);
        wr(`FFR_ADDR_CTRL, 32'hB3);
        expect_rd(`FFR_ADDR_FAIL, 32'h0);
        pins(2'b01);
        wr(`FFR_ADDR_IRQ_STAT, 32'h3);
        pins(2'b00);
        stall <= 2'b10;
        idle(40);
        expect_rd(`FFR_ADDR_FAIL, 32'h2);
        recover();
        $display("failure test done");
    endtask : t_fail
    task automatic t_enable();
        for (int ch = 0; ch < 2; ch++) begin
            stall[ch] <= 1'b1;
            idle(40);
            expect_rd(`FFR_ADDR_FAIL, 32'h1 << ch);
            wr(`FFR_ADDR_CTRL, 32'h33 & ~(32'h1 << ch));
            expect_rd(`FFR_ADDR_FAIL, 32'h0);
            pins(2'b01);
            idle(40);
            expect_rd(`FFR_ADDR_FAIL, 32'h0);
            wr(`FFR_ADDR_CTRL, 32'h33);
            idle(40);
            expect_rd(`FFR_ADDR_FAIL, 32'h1 << ch);
            recover();
        end
        wr(`FFR_ADDR_CTRL, 32'h30);
        pins(2'b00);
        wr(`FFR_ADDR_CTRL, 32'h33);
        $display("enable test done");
    endtask : t_enable
    task automatic t_window();
        wr(`FFR_ADDR_DUTY_TGT, 32'h40);
        wr(`FFR_ADDR_CTRL, 32'h03);
        wr(`FFR_ADDR_DUTY_TGT, 32'h0);
        stall <= 2'b01;
        idle(40);
        expect_rd(`FFR_ADDR_FAIL, 32'h0);
        wr(`FFR_ADDR_CTRL, 32'h73);
        idle(40);
        expect_rd(`FFR_ADDR_DUTY_NOW, 32'h0);
        expect_rd(`FFR_ADDR_FAIL, 32'h1);
        recover();
        wr(`FFR_ADDR_CTRL, 32'h3B);
        wr(`FFR_ADDR_DUTY_TGT, 32'h80);
        stall <= 2'b01;
        idle(40);
        expect_rd(`FFR_ADDR_FAIL, 32'h0);
        wr(`FFR_ADDR_DUTY_TGT, 32'hFF);
        idle(40);
        expect_rd(`FFR_ADDR_FAIL, 32'h1);
        check({31'h0, pwmOut}, 32'h1);
        recover();
        $display("window test done");
    endtask : t_window
    task automatic t_ramp();
        logic [31:0] q;
        int          cyc;
        int          step;
        realtime     t0;
        for (int r = 0; r < 3; r++) begin
            step = 8 >> r;
            wr(`FFR_ADDR_CTRL, 32'h33);
            wr(`FFR_ADDR_DUTY_TGT, 32'h0);
            wr(`FFR_ADDR_CTRL, 32'h03 | (r << 4));
            t0 = $realtime;
            wr(`FFR_ADDR_DUTY_TGT, 32'h8);
            q = 32'h0;
            while (q !== 32'h8) begin
                bus(1'b0, `FFR_ADDR_DUTY_NOW, 32'h0, q);
            end
            cyc = int'(($realtime - t0) / 100.0);
            check({31'h0, cyc >= 7 * step && cyc <= 8 * step + 10}, 32'h1);
        end
        wr(`FFR_ADDR_CTRL, 32'h33);
        wr(`FFR_ADDR_DUTY_TGT, 32'h50);
        expect_rd(`FFR_ADDR_DUTY_NOW, 32'h50);
        $display("ramp test done");
    endtask : t_ramp
    // pulse feature only at the lowest pwm rate
    task automatic t_pulse();
        for (int f = 0; f < 4; f++) begin
            wr(`FFR_ADDR_CFG, f);
            wr(`FFR_ADDR_CTRL, 32'h37);
            idle(3);
            check({31'h0, pulseFeatureActive}, {31'h0, f == 0});
            wr(`FFR_ADDR_CTRL, 32'h33);
            idle(3);
            check({31'h0, pulseFeatureActive}, 32'h0);
        end
        $display("pulse test done");
    endtask : t_pulse
    initial begin
        idle(20);
        reset <= 1'b0;
        t_regs();
        t_fail();
        t_enable();
        t_window();
        t_ramp();
        t_pulse();
        end_of_test();
    end
    initial begin
        idle(20000);
        n_mismatch++;
        end_of_test();
    end
endmodule : test_fan_fail_and_ramp_control
`default_nettype wire

// [pkg/ffr_defines.svh]
// offsets, fields, resets and timing of the fan fail block
`ifndef FFR_DEFINES_SVH
`define FFR_DEFINES_SVH

`define FFR_SYS_CLK_HZ          10000000
`define FFR_SYS_CLK_MHZ         10

// 1/256 duty per 125 ms = 3.125 %/s
`define FFR_RAMP_SLOW_STEP_US   125000
`define FFR_TACH_TIMEOUT_US     1000000

`define FFR_PWM_STEPS           256
`define FFR_PWM_HZ_33           33
`define FFR_PWM_HZ_150          150
`define FFR_PWM_HZ_1500         1500
`define FFR_PWM_HZ_25K          25000

`define FFR_IDX_CTRL            8'h02
`define FFR_ADDR_CTRL           8'h08
`define FFR_ADDR_CFG            8'h0C
`define FFR_ADDR_DUTY_TGT       8'h10
`define FFR_ADDR_DUTY_NOW       8'h14
`define FFR_ADDR_FAIL           8'h18
`define FFR_ADDR_IRQ_STAT       8'h1C
`define FFR_ADDR_IRQ_MASK       8'h20

`define FFR_CTRL_RESET          8'h03
`define FFR_CFG_RESET           3'h0
`define FFR_CTRL_CLEAR_BIT      7
`define FFR_DUTY_FULL           8'hFF
`define FFR_DUTY_ZERO           8'h00

`endif

// [pkg/ffr_pkg.sv]
// types shared by the fan fail and ramp control block
package ffr_pkg;

    typedef enum logic [1:0] {
        RAMP_SLOW      = 2'b00,
        RAMP_SLOW_MED  = 2'b01,
        RAMP_MED_FAST  = 2'b10,
        RAMP_IMMEDIATE = 2'b11
    } ffr_ramp_e_t;

    typedef enum logic [1:0] {
        PWM_33HZ   = 2'b00,
        PWM_150HZ  = 2'b01,
        PWM_1500HZ = 2'b10,
        PWM_25KHZ  = 2'b11
    } ffr_pwm_freq_t;

    typedef enum logic [2:0] {
        RS_HOLD = 3'b001,
        RS_UP   = 3'b010,
        RS_DOWN = 3'b100
    } ffr_ramp_state_t;

    typedef struct packed {
        logic        failure_flag_clear;
        logic        zero_duty_detect_enable;
        ffr_ramp_e_t ramp;
        logic        detect_at_full_duty_only;
        logic        pulse_feature_enable;
        logic        speed_input_two_enable;
        logic        speed_input_one_enable;
    } ffr_ctrl_t;

    typedef struct packed {
        logic          failPinLatched;
        ffr_pwm_freq_t pwmFreq;
    } ffr_cfg_t;

endpackage : ffr_pkg

// [rtl/ffr_fail_chan.sv]
// one speed input: missing-pulse watchdog and sticky failure flag
`timescale 1ns/1ps
`default_nettype none
module ffr_fail_chan #(
    parameter int unsigned TIMEOUT_CYCLES = 10000000
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic speedIn,
    input  wire logic enable,
    input  wire logic allowed,
    input  wire logic clear,
    output logic      failFlag_q,
    output logic      failEvent_q
);
    logic        prev_q;
    logic [31:0] cnt_q;
    logic        expired;

    assign expired = (cnt_q >= 32'(TIMEOUT_CYCLES) - 32'h1);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_q <= 1'b0;
            cnt_q  <= 32'h0;
        end else if (ce) begin
            prev_q <= speedIn;
            if (!enable || !allowed || (speedIn && !prev_q) || expired) begin
                cnt_q <= 32'h0;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            failFlag_q  <= 1'b0;
            failEvent_q <= 1'b0;
        end else if (ce) begin
            failEvent_q <= enable && allowed && expired && !failFlag_q;
            if (enable && allowed && expired) begin
                failFlag_q <= 1'b1;
            end else if (clear || !enable) begin
                failFlag_q <= 1'b0;
            end
        end
    end
endmodule : ffr_fail_chan
`default_nettype wire

// [rtl/ffr_fan_fail_ramp.sv]
// fan failure detection and duty ramp control with ahb-lite registers
//
// Functional notes
// - Writing one to the failure-clear bit zeroes every fan failure flag.
// - After a clear, a flag is set again whenever a new failure is seen on its channel.
// - In interrupt mode the failure-clear write also releases the fail output pin.
// - The failure-clear bit returns to zero by itself and always reads as zero.
// - With zero-duty detection off, detection is suppressed at zero duty or ramping to zero.
// - With zero-duty detection on and full-duty-only off, detection runs at every duty value including zero.
// - The ramp field selects 3.125, 6.25 or 12.5 percent per second, or immediate change.
// - With full-duty-only set, failure is evaluated only while duty is 100 percent.
// - The pulse feature bit enables the pulse function, effective only at 33 Hz PWM.
// - Clearing input two enable stops its monitoring and clears its flag, and clears the pin in interrupt mode or when flag one is clear.
// - Setting input two enable turns its monitoring on; it is one by default.
// - Clearing input one enable stops its monitoring and clears its flag, and clears the pin in interrupt mode or when flag two is clear.
// - Setting input one enable turns its monitoring on; it is one by default.
// - The control register holds 03h as its nonvolatile factory value.
`timescale 1ns/1ps
`default_nettype none
`include "ffr_defines.svh"
module ffr_fan_fail_ramp
    import ffr_pkg::*;
#(
    parameter int unsigned RAMP_STEP_CYCLES = `FFR_RAMP_SLOW_STEP_US * `FFR_SYS_CLK_MHZ,
    parameter int unsigned TACH_TIMEOUT_CYC = `FFR_TACH_TIMEOUT_US * `FFR_SYS_CLK_MHZ
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        speedInputOne,
    input  wire logic        speedInputTwo,
    output logic             pwmOut,
    output logic             pulseFeatureActive,
    output logic             failFlagPinOut,
    output logic             failFlagPinOe,
    output logic             irq
);
    localparam int PRE_33   = `FFR_SYS_CLK_HZ / (`FFR_PWM_HZ_33 * `FFR_PWM_STEPS);
    localparam int PRE_150  = `FFR_SYS_CLK_HZ / (`FFR_PWM_HZ_150 * `FFR_PWM_STEPS);
    localparam int PRE_1500 = `FFR_SYS_CLK_HZ / (`FFR_PWM_HZ_1500 * `FFR_PWM_STEPS);
    localparam int PRE_25K  = `FFR_SYS_CLK_HZ / (`FFR_PWM_HZ_25K * `FFR_PWM_STEPS);

    ffr_ctrl_t   ctrl_q;
    ffr_cfg_t    cfg_q;
    logic [7:0]  dutyTarget_q;
    logic [1:0]  irqStat_q;
    logic [1:0]  irqMask_q;
    logic        clearPulse_q;
    logic        pinLatch_q;
    logic        wrPend_q;
    logic [7:0]  wrAddr_q;
    logic        rdPend_q;
    logic [7:0]  rdAddr_q;
    logic [15:0] preCnt_q;
    logic [7:0]  pwmCnt_q;
    logic [15:0] preLimit;
    logic [7:0]  duty;
    logic        rampDown;
    logic        detectAllowed;
    logic        flagOne;
    logic        flagTwo;
    logic        eventOne;
    logic        eventTwo;
    logic        addrTaken;
    logic [31:0] rdMux;

    assign addrTaken = ce && hsel && hready && htrans[1];

    // bus address and data phases
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPend_q  <= 1'b0;
            wrAddr_q  <= 8'h00;
            rdPend_q  <= 1'b0;
            rdAddr_q  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
        end else if (ce) begin
            wrPend_q <= addrTaken && hwrite;
            wrAddr_q <= haddr;
            rdPend_q <= addrTaken && !hwrite;
            if (addrTaken && !hwrite) begin
                rdAddr_q  <= haddr;
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (rdPend_q) begin
                hrdata <= rdMux;
            end
        end
    end

    // register read mux
    always_comb begin
        rdMux = 32'h0;
        if (rdAddr_q == `FFR_ADDR_CTRL) begin
            rdMux = {24'h0, ctrl_q};
        end else if (rdAddr_q == `FFR_ADDR_CFG) begin
            rdMux = {29'h0, cfg_q};
        end else if (rdAddr_q == `FFR_ADDR_DUTY_TGT) begin
            rdMux = {24'h0, dutyTarget_q};
        end else if (rdAddr_q == `FFR_ADDR_DUTY_NOW) begin
            rdMux = {24'h0, duty};
        end else if (rdAddr_q == `FFR_ADDR_FAIL) begin
            rdMux = {30'h0, flagTwo, flagOne};
        end else if (rdAddr_q == `FFR_ADDR_IRQ_STAT) begin
            rdMux = {30'h0, irqStat_q};
        end else if (rdAddr_q == `FFR_ADDR_IRQ_MASK) begin
            rdMux = {30'h0, irqMask_q};
        end
    end

    // control register and clear strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q       <= ffr_ctrl_t'(`FFR_CTRL_RESET);
            clearPulse_q <= 1'b0;
        end else if (ce) begin
            clearPulse_q <= 1'b0;
            if (wrPend_q && wrAddr_q == `FFR_ADDR_CTRL) begin
                ctrl_q <= ffr_ctrl_t'(hwdata[7:0]);
                ctrl_q.failure_flag_clear <= 1'b0;
                clearPulse_q <= hwdata[`FFR_CTRL_CLEAR_BIT];
            end
        end
    end

    // cfg, duty target, irq mask
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg_q        <= ffr_cfg_t'(`FFR_CFG_RESET);
            dutyTarget_q <= `FFR_DUTY_ZERO;
            irqMask_q    <= 2'h0;
        end else if (ce && wrPend_q) begin
            if (wrAddr_q == `FFR_ADDR_CFG) begin
                cfg_q <= ffr_cfg_t'(hwdata[2:0]);
            end else if (wrAddr_q == `FFR_ADDR_DUTY_TGT) begin
                dutyTarget_q <= hwdata[7:0];
            end else if (wrAddr_q == `FFR_ADDR_IRQ_MASK) begin
                irqMask_q <= hwdata[1:0];
            end
        end
    end

    ffr_ramp_gen #(
        .STEP_CYCLES (RAMP_STEP_CYCLES)
    ) u_ramp (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .ce          (ce),
        .target      (dutyTarget_q),
        .rate        (ctrl_q.ramp),
        .duty_q      (duty),
        .rampingDown (rampDown)
    );

    // detection window by duty
    always_comb begin
        if (ctrl_q.detect_at_full_duty_only) begin
            detectAllowed = (duty == `FFR_DUTY_FULL);
        end else if (ctrl_q.zero_duty_detect_enable) begin
            detectAllowed = 1'b1;
        end else begin
            detectAllowed = !((duty == `FFR_DUTY_ZERO)
                              || (rampDown && dutyTarget_q == `FFR_DUTY_ZERO));
        end
    end

    ffr_fail_chan #(
        .TIMEOUT_CYCLES (TACH_TIMEOUT_CYC)
    ) u_chan_one (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .ce          (ce),
        .speedIn     (speedInputOne),
        .enable      (ctrl_q.speed_input_one_enable),
        .allowed     (detectAllowed),
        .clear       (clearPulse_q),
        .failFlag_q  (flagOne),
        .failEvent_q (eventOne)
    );

    ffr_fail_chan #(
        .TIMEOUT_CYCLES (TACH_TIMEOUT_CYC)
    ) u_chan_two (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .ce          (ce),
        .speedIn     (speedInputTwo),
        .enable      (ctrl_q.speed_input_two_enable),
        .allowed     (detectAllowed),
        .clear       (clearPulse_q),
        .failFlag_q  (flagTwo),
        .failEvent_q (eventTwo)
    );

    // fail pin latch for interrupt mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinLatch_q <= 1'b0;
        end else if (ce) begin
            if (eventOne || eventTwo) begin
                pinLatch_q <= 1'b1;
            end else if (clearPulse_q) begin
                pinLatch_q <= 1'b0;
            end else if (!ctrl_q.speed_input_one_enable
                         || !ctrl_q.speed_input_two_enable) begin
                pinLatch_q <= 1'b0;
            end
        end
    end

    // open-drain fail pin, low when asserted
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            failFlagPinOut <= 1'b0;
            failFlagPinOe  <= 1'b0;
        end else if (ce) begin
            failFlagPinOut <= 1'b0;
            failFlagPinOe  <= cfg_q.failPinLatched ? pinLatch_q : (flagOne || flagTwo);
        end
    end

    // sticky w1c irq status, set wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqStat_q <= 2'h0;
            irq       <= 1'b0;
        end else if (ce) begin
            if (wrPend_q && wrAddr_q == `FFR_ADDR_IRQ_STAT) begin
                irqStat_q <= (irqStat_q & ~hwdata[1:0]) | {eventTwo, eventOne};
            end else begin
                irqStat_q <= irqStat_q | {eventTwo, eventOne};
            end
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // pwm prescale per selected frequency
    always_comb begin
        case (cfg_q.pwmFreq)
            PWM_150HZ:  preLimit = 16'(PRE_150);
            PWM_1500HZ: preLimit = 16'(PRE_1500);
            PWM_25KHZ:  preLimit = 16'(PRE_25K);
            default:    preLimit = 16'(PRE_33);
        endcase
    end

    // pwm counter and output, 0xFF is full on
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            preCnt_q <= 16'h0;
            pwmCnt_q <= 8'h00;
            pwmOut   <= 1'b0;
        end else if (ce) begin
            if (preCnt_q >= preLimit - 16'h1) begin
                preCnt_q <= 16'h0;
                pwmCnt_q <= pwmCnt_q + 8'h01;
            end else begin
                preCnt_q <= preCnt_q + 16'h1;
            end
            pwmOut <= (duty == `FFR_DUTY_FULL) || (pwmCnt_q < duty);
        end
    end

    // pulse feature at 33 Hz only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pulseFeatureActive <= 1'b0;
        end else if (ce) begin
            pulseFeatureActive <= ctrl_q.pulse_feature_enable
                                  && (cfg_q.pwmFreq == PWM_33HZ);
        end
    end

endmodule : ffr_fan_fail_ramp
`default_nettype wire

// [rtl/ffr_ramp_gen.sv]
// duty-cycle ramp toward a target at a selectable rate
`timescale 1ns/1ps
`default_nettype none
module ffr_ramp_gen
    import ffr_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = 1250000
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic [7:0]  target,
    input  wire ffr_ramp_e_t rate,
    output logic      [7:0]  duty_q,
    output logic             rampingDown
);
    ffr_ramp_state_t state_q;
    logic [31:0]     cnt_q;
    logic [31:0]     limit;

    always_comb begin
        case (rate)
            RAMP_SLOW_MED: limit = 32'(STEP_CYCLES >> 1);
            RAMP_MED_FAST: limit = 32'(STEP_CYCLES >> 2);
            default:       limit = 32'(STEP_CYCLES);
        endcase
        if (limit == 32'h0) begin
            limit = 32'h1;
        end
    end

    assign rampingDown = (state_q == RS_DOWN);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= RS_HOLD;
            duty_q  <= 8'h00;
            cnt_q   <= 32'h0;
        end else if (ce) begin
            case (state_q)
                RS_HOLD: begin
                    cnt_q <= 32'h0;
                    if (target > duty_q) begin
                        state_q <= RS_UP;
                    end else if (target < duty_q) begin
                        state_q <= RS_DOWN;
                    end
                end
                RS_UP, RS_DOWN: begin
                    if (rate == RAMP_IMMEDIATE || target == duty_q
                        || ((state_q == RS_UP) != (target > duty_q))) begin
                        duty_q  <= (rate == RAMP_IMMEDIATE) ? target : duty_q;
                        state_q <= RS_HOLD;
                    end else if (cnt_q >= limit - 32'h1) begin
                        duty_q <= (state_q == RS_UP) ? duty_q + 8'h01 : duty_q - 8'h01;
                        cnt_q  <= 32'h0;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                default: state_q <= RS_HOLD;
            endcase
        end
    end
endmodule : ffr_ramp_gen
`default_nettype wire
